/* File: design/sbbs_map.svh */
`ifndef SBBS_MAP_SVH
`define SBBS_MAP_SVH

// Pin codes {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n}
`define SBBS_PINS_DESEL 4'hF
`define SBBS_PINS_NOP 4'h7
`define SBBS_PINS_HALT 4'h6
`define SBBS_PINS_READ 4'h5
`define SBBS_PINS_WRITE 4'h4
`define SBBS_PINS_OPEN 4'h3
`define SBBS_PINS_CLOSE 4'h2
`define SBBS_PINS_REFRESH 4'h1
`define SBBS_PINS_CONFIG 4'h0

// Default cycle counts
`define SBBS_BURST_LEN 2
`define SBBS_PRE_CYC 3
`define SBBS_WREC_CYC 2
`define SBBS_MAX_CNT 255
`define SBBS_BUF_DEPTH 2

// Counter steps
`define SBBS_CNT_ONE 8'h01
`define SBBS_CNT_ZERO 8'h00

`endif

/* File: design/sbbs_pkg.sv */
package sbbs_pkg;

`include "sbbs_map.svh"

typedef enum logic [3:0] {
   chip_unselected,
   nop_cmd,
   burst_halt_cmd,
   fetch_burst_cmd,
   store_burst_cmd,
   row_open_cmd,
   bank_close_cmd,
   refresh_cmd,
   config_load_cmd
} sbbs_cmd_t;

typedef enum logic [3:0] {
   bank_idle,
   bank_active,
   bank_read,
   bank_write,
   bank_read_ac,
   bank_write_ac,
   bank_wrec,
   bank_wrec_ac,
   bank_precharge
} sbbs_bank_st_t;

typedef enum logic [3:0] {
   op_nop,
   op_open,
   op_read,
   op_read_ac,
   op_write,
   op_write_ac,
   op_halt,
   op_close,
   op_close_all
} sbbs_op_t;

typedef struct packed {
   sbbs_bank_st_t st;
   logic [7:0] cnt;
   logic illegal;
   logic rd;
   logic wr;
   logic start;
} sbbs_step_t;

function automatic sbbs_cmd_t sbbs_decode(input logic [3:0] pins);
   sbbs_cmd_t c;
   c = nop_cmd;
   if (pins[3]) begin
      c = chip_unselected;
   end else begin
      case (pins)
         `SBBS_PINS_NOP: c = nop_cmd;
         `SBBS_PINS_HALT: c = burst_halt_cmd;
         `SBBS_PINS_READ: c = fetch_burst_cmd;
         `SBBS_PINS_WRITE: c = store_burst_cmd;
         `SBBS_PINS_OPEN: c = row_open_cmd;
         `SBBS_PINS_CLOSE: c = bank_close_cmd;
         `SBBS_PINS_REFRESH: c = refresh_cmd;
         `SBBS_PINS_CONFIG: c = config_load_cmd;
         default: c = nop_cmd;
      endcase
   end
   return c;
endfunction

// One clock of one bank; shared by the device and the controller mirror
function automatic sbbs_step_t sbbs_bank_step(
   input sbbs_bank_st_t st,
   input logic [7:0] cnt,
   input sbbs_cmd_t cmd,
   input logic hit,
   input logic ac,
   input logic [7:0] bl,
   input logic [7:0] pre_c,
   input logic [7:0] wr_c
);
   sbbs_step_t r;
   logic mine;
   logic col;
   logic quiet;
   logic other_col;
   logic word;
   logic fin;
   r = '{st: st, cnt: cnt, illegal: 1'b0, rd: 1'b0, wr: 1'b0,
         start: 1'b0};
   word = 1'b0;
   fin = 1'b0;
   col = (cmd == fetch_burst_cmd) || (cmd == store_burst_cmd);
   case (cmd)
      burst_halt_cmd, refresh_cmd, config_load_cmd: mine = 1'b1;
      bank_close_cmd: mine = hit || ac;
      default: mine = hit;
   endcase
   quiet = !mine || (cmd == chip_unselected) || (cmd == nop_cmd);
   other_col = col && !hit;
   case (st)
      bank_idle: begin
         if (!quiet && col) begin
            r.illegal = 1'b1;
         end else if (!quiet && cmd == row_open_cmd) begin
            r.st = bank_active;
         end
      end
      bank_active, bank_wrec: begin
         if (quiet) begin
            if (st == bank_wrec) begin
               r.cnt = cnt - `SBBS_CNT_ONE;
               if (cnt == `SBBS_CNT_ONE) begin
                  r.st = bank_active;
               end
            end
         end else if (col) begin
            r.start = 1'b1;
         end else if (cmd == bank_close_cmd && st == bank_active) begin
            r.st = bank_precharge;
            r.cnt = pre_c;
         end else if (cmd != burst_halt_cmd) begin
            r.illegal = 1'b1;
         end
      end
      bank_read, bank_write: begin
         if (quiet) begin
            word = !other_col;
            fin = other_col;
         end else if (col) begin
            r.start = 1'b1;
         end else if (cmd == burst_halt_cmd) begin
            r.st = bank_active;
         end else if (cmd == bank_close_cmd) begin
            r.st = bank_precharge;
            r.cnt = pre_c;
         end else begin
            r.illegal = 1'b1;
         end
      end
      bank_read_ac, bank_write_ac: begin
         if (quiet) begin
            word = !other_col;
            fin = other_col;
         end else begin
            r.illegal = 1'b1;
         end
      end
      bank_wrec_ac: begin
         if (quiet || cmd == burst_halt_cmd) begin
            r.cnt = cnt - `SBBS_CNT_ONE;
            if (cnt == `SBBS_CNT_ONE) begin
               r.st = bank_precharge;
               r.cnt = pre_c;
            end
         end else begin
            r.illegal = 1'b1;
         end
      end
      bank_precharge: begin
         // A repeated close only counts on, never reloads the timer
         if (quiet || cmd == burst_halt_cmd || cmd == bank_close_cmd) begin
            r.cnt = cnt - `SBBS_CNT_ONE;
            if (cnt == `SBBS_CNT_ONE) begin
               r.st = bank_idle;
            end
         end else begin
            r.illegal = 1'b1;
         end
      end
      default: r.st = bank_idle;
   endcase
   if (r.start) begin
      if (cmd == fetch_burst_cmd) begin
         r.st = ac ? bank_read_ac : bank_read;
      end else begin
         r.st = ac ? bank_write_ac : bank_write;
      end
      r.cnt = bl;
      word = 1'b1;
   end
   if (word) begin
      r.rd = (r.st == bank_read) || (r.st == bank_read_ac);
      r.wr = !r.rd;
      r.cnt = r.cnt - `SBBS_CNT_ONE;
      fin = (r.cnt == `SBBS_CNT_ZERO);
   end
   if (fin) begin
      case (r.st)
         bank_read: r.st = bank_active;
         bank_write: begin
            r.st = bank_wrec;
            r.cnt = wr_c;
         end
         bank_read_ac: begin
            r.st = bank_precharge;
            r.cnt = pre_c;
         end
         bank_write_ac: begin
            r.st = bank_wrec_ac;
            r.cnt = wr_c;
         end
         default: r.st = r.st;
      endcase
   end
   return r;
endfunction

endpackage

/* File: design/sbbs_if.sv */
`timescale 1ns/100ps
interface sbbs_if #(
   parameter int COL_W = 4,
   parameter int DATA_W = 16
);
   logic chip_select_n;
   logic row_strobe_n;
   logic column_strobe_n;
   logic write_enable_n;
   logic bank_select_bit;
   logic autoclose_addr_bit;
   logic [COL_W-1:0] col_addr;
   logic [DATA_W-1:0] wr_data;
   logic [DATA_W-1:0] rd_data;
   logic rd_valid;

   modport ctl(
      output chip_select_n,
      output row_strobe_n,
      output column_strobe_n,
      output write_enable_n,
      output bank_select_bit,
      output autoclose_addr_bit,
      output col_addr,
      output wr_data,
      input rd_data,
      input rd_valid
   );

   modport mem(
      input chip_select_n,
      input row_strobe_n,
      input column_strobe_n,
      input write_enable_n,
      input bank_select_bit,
      input autoclose_addr_bit,
      input col_addr,
      input wr_data,
      output rd_data,
      output rd_valid
   );
endinterface

/* File: design/sbbs_ctl.sv */
`timescale 1ns/100ps
`include "sbbs_map.svh"
module sbbs_ctl #(
   parameter int BURST_LEN = `SBBS_BURST_LEN,
   parameter int PRE_CYC = `SBBS_PRE_CYC,
   parameter int WREC_CYC = `SBBS_WREC_CYC,
   parameter int COL_W = 4,
   parameter int DATA_W = 16
) (
   input wire logic clk_sys,
   input wire logic rstn,
   sbbs_if.ctl lnk,
   input wire logic req_valid,
   output logic req_ready,
   input wire sbbs_pkg::sbbs_op_t req_op,
   input wire logic req_bank,
   input wire logic [COL_W-1:0] req_col,
   input wire logic [DATA_W-1:0] req_wdata,
   output logic req_refused,
   output logic rd_word_valid,
   input wire logic rd_word_ready,
   output logic [DATA_W-1:0] rd_word
);
   import sbbs_pkg::*;

   // Whole bursts must fit the read buffer, since the link cannot stall
   if (BURST_LEN < 1 || BURST_LEN > `SBBS_BUF_DEPTH ||
       PRE_CYC < 1 || PRE_CYC > `SBBS_MAX_CNT ||
       WREC_CYC < 1 || WREC_CYC > `SBBS_MAX_CNT) begin : g_bad
      $error("sbbs_ctl: count parameter out of range");
   end

   sbbs_bank_st_t st_reg [2];
   sbbs_bank_st_t st_next [2];
   logic [7:0] cnt_reg [2];
   logic [7:0] cnt_next [2];
   logic [3:0] pins_reg, pins_next;
   logic bank_reg, bank_next;
   logic ac_reg, ac_next;
   logic [COL_W-1:0] col_reg, col_next;
   logic [DATA_W-1:0] wd_reg, wd_next;
   logic refused_reg, refused_next;
   logic ready_reg, ready_next;
   logic p1_reg, p1_next, p2_reg, p2_next;
   logic ov_reg, ov_next, sv_reg, sv_next;
   logic [DATA_W-1:0] od_reg, od_next, sd_reg, sd_next;

   always_comb begin
      sbbs_cmd_t cmd;
      sbbs_step_t s;
      logic ac;
      logic bad;
      logic rd_any;
      logic reading;
      cmd = chip_unselected;
      s = '0;
      ac = 1'b0;
      bad = 1'b0;
      rd_any = 1'b0;
      reading = 1'b0;
      if (req_valid && ready_reg) begin
         case (req_op)
            op_open: cmd = row_open_cmd;
            op_read: cmd = fetch_burst_cmd;
            op_read_ac: begin
               cmd = fetch_burst_cmd;
               ac = 1'b1;
            end
            op_write: cmd = store_burst_cmd;
            op_write_ac: begin
               cmd = store_burst_cmd;
               ac = 1'b1;
            end
            op_halt: cmd = burst_halt_cmd;
            op_close: cmd = bank_close_cmd;
            op_close_all: begin
               cmd = bank_close_cmd;
               ac = 1'b1;
            end
            default: cmd = nop_cmd;
         endcase
      end
      for (int b = 0; b < 2; b++) begin
         s = sbbs_bank_step(st_reg[b], cnt_reg[b], cmd, req_bank == 1'(b),
            ac, 8'(BURST_LEN), 8'(PRE_CYC), 8'(WREC_CYC));
         bad = bad | s.illegal;
      end
      // Forbidden for a bank's tracked state: never reaches the pins
      if (bad) begin
         cmd = chip_unselected;
      end
      for (int b = 0; b < 2; b++) begin
         s = sbbs_bank_step(st_reg[b], cnt_reg[b], cmd, req_bank == 1'(b),
            ac, 8'(BURST_LEN), 8'(PRE_CYC), 8'(WREC_CYC));
         st_next[b] = s.st;
         cnt_next[b] = s.cnt;
         rd_any = rd_any | s.rd;
         reading = reading | (s.st == bank_read) | (s.st == bank_read_ac);
      end
      case (cmd)
         nop_cmd: pins_next = `SBBS_PINS_NOP;
         burst_halt_cmd: pins_next = `SBBS_PINS_HALT;
         fetch_burst_cmd: pins_next = `SBBS_PINS_READ;
         store_burst_cmd: pins_next = `SBBS_PINS_WRITE;
         row_open_cmd: pins_next = `SBBS_PINS_OPEN;
         bank_close_cmd: pins_next = `SBBS_PINS_CLOSE;
         default: pins_next = `SBBS_PINS_DESEL;
      endcase
      refused_next = bad;
      bank_next = bank_reg;
      ac_next = ac_reg;
      col_next = col_reg;
      wd_next = wd_reg;
      if (req_valid && ready_reg) begin
         bank_next = req_bank;
         ac_next = ac;
         col_next = req_col;
         wd_next = req_wdata;
      end
      p1_next = rd_any;
      p2_next = p1_reg;
      ov_next = ov_reg;
      od_next = od_reg;
      sv_next = sv_reg;
      sd_next = sd_reg;
      if (ov_reg && rd_word_ready) begin
         ov_next = sv_reg;
         od_next = sd_reg;
         sv_next = 1'b0;
      end
      if (lnk.rd_valid) begin
         if (!ov_next) begin
            ov_next = 1'b1;
            od_next = lnk.rd_data;
         end else begin
            sv_next = 1'b1;
            sd_next = lnk.rd_data;
         end
      end
      // Stall requests while read words are owed or still buffered
      ready_next = !ov_next && !sv_next && !p1_next && !p2_next && !reading;
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st_reg <= '{bank_idle, bank_idle};
         cnt_reg <= '{`SBBS_CNT_ZERO, `SBBS_CNT_ZERO};
         pins_reg <= `SBBS_PINS_DESEL;
         bank_reg <= 1'b0;
         ac_reg <= 1'b0;
         col_reg <= '0;
         wd_reg <= '0;
         refused_reg <= 1'b0;
         ready_reg <= 1'b0;
         p1_reg <= 1'b0;
         p2_reg <= 1'b0;
         ov_reg <= 1'b0;
         sv_reg <= 1'b0;
         od_reg <= '0;
         sd_reg <= '0;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         pins_reg <= pins_next;
         bank_reg <= bank_next;
         ac_reg <= ac_next;
         col_reg <= col_next;
         wd_reg <= wd_next;
         refused_reg <= refused_next;
         ready_reg <= ready_next;
         p1_reg <= p1_next;
         p2_reg <= p2_next;
         ov_reg <= ov_next;
         sv_reg <= sv_next;
         od_reg <= od_next;
         sd_reg <= sd_next;
      end
   end

   assign lnk.chip_select_n = pins_reg[3];
   assign lnk.row_strobe_n = pins_reg[2];
   assign lnk.column_strobe_n = pins_reg[1];
   assign lnk.write_enable_n = pins_reg[0];
   assign lnk.bank_select_bit = bank_reg;
   assign lnk.autoclose_addr_bit = ac_reg;
   assign lnk.col_addr = col_reg;
   assign lnk.wr_data = wd_reg;
   assign req_ready = ready_reg;
   assign req_refused = refused_reg;
   assign rd_word_valid = ov_reg;
   assign rd_word = od_reg;
endmodule

/* File: design/sbbs_mem.sv */
`timescale 1ns/100ps
// Functional notes
// - Burst halt ends read, row stays open
// - New read restarts read burst at column
// - Write during read starts write burst
// - Close ends read into precharge; others forbidden
// - Write burst continues; then write recovery
// - Burst halt ends write, row active
// - Read during write starts read burst
// - New write restarts write at column
// - Close ends write into precharge; others forbidden
// - Read autoclose: only idle cycles, then precharge
// - Write autoclose: idle cycles, recovery, then precharge
// - Precharge ignores halt/idle, idles after timer
// - Repeated close never restarts precharge timer
// - All pins sampled only at rising edge
// - Read burst continues, then row active
`include "sbbs_map.svh"
module sbbs_mem #(
   parameter int BURST_LEN = `SBBS_BURST_LEN,
   parameter int PRE_CYC = `SBBS_PRE_CYC,
   parameter int WREC_CYC = `SBBS_WREC_CYC,
   parameter int COL_W = 4,
   parameter int DATA_W = 16
) (
   input wire logic clk_sys,
   input wire logic rstn,
   sbbs_if.mem lnk,
   output logic illegal_cmd,
   output logic burst_active,
   output logic [7:0] bank_state
);
   import sbbs_pkg::*;

   localparam int DEPTH = 1 << COL_W;

   if (BURST_LEN < 1 || BURST_LEN > `SBBS_MAX_CNT ||
       PRE_CYC < 1 || PRE_CYC > `SBBS_MAX_CNT ||
       WREC_CYC < 1 || WREC_CYC > `SBBS_MAX_CNT ||
       COL_W < 1) begin : g_bad
      $error("sbbs_mem: parameter out of range");
   end

   sbbs_bank_st_t st_reg [2];
   sbbs_bank_st_t st_next [2];
   logic [7:0] cnt_reg [2];
   logic [7:0] cnt_next [2];
   logic [COL_W-1:0] col_reg [2];
   logic [COL_W-1:0] col_next [2];
   // Rows are not modelled: each bank keeps one row of words
   logic [DATA_W-1:0] store [2][DEPTH];
   logic [DATA_W-1:0] rd_data_reg, rd_data_next;
   logic rd_valid_reg, rd_valid_next;
   logic illegal_reg, illegal_next;
   logic busy_reg, busy_next;
   logic [7:0] state_reg, state_next;
   logic wr_en;
   logic wr_bank;
   logic [COL_W-1:0] wr_col;
   logic [DATA_W-1:0] wr_word;

   function automatic logic in_burst(input sbbs_bank_st_t s);
      return (s == bank_read) || (s == bank_write) ||
             (s == bank_read_ac) || (s == bank_write_ac);
   endfunction

   always_comb begin
      sbbs_cmd_t cmd;
      sbbs_step_t s;
      logic [COL_W-1:0] addr;
      cmd = sbbs_decode({lnk.chip_select_n, lnk.row_strobe_n,
         lnk.column_strobe_n, lnk.write_enable_n});
      addr = '0;
      s = '0;
      rd_valid_next = 1'b0;
      rd_data_next = rd_data_reg;
      illegal_next = 1'b0;
      busy_next = 1'b0;
      wr_en = 1'b0;
      wr_bank = 1'b0;
      wr_col = '0;
      wr_word = lnk.wr_data;
      for (int b = 0; b < 2; b++) begin
         s = sbbs_bank_step(st_reg[b], cnt_reg[b], cmd,
            lnk.bank_select_bit == 1'(b), lnk.autoclose_addr_bit,
            8'(BURST_LEN), 8'(PRE_CYC), 8'(WREC_CYC));
         // A forbidden command leaves the bank exactly as it was
         st_next[b] = s.st;
         cnt_next[b] = s.cnt;
         addr = s.start ? lnk.col_addr : col_reg[b];
         col_next[b] = col_reg[b];
         if (s.rd || s.wr) begin
            col_next[b] = addr + 1'b1;
         end
         if (s.rd) begin
            rd_valid_next = 1'b1;
            rd_data_next = store[b][addr];
         end
         if (s.wr) begin
            wr_en = 1'b1;
            wr_bank = 1'(b);
            wr_col = addr;
         end
         illegal_next = illegal_next | s.illegal;
         busy_next = busy_next | in_burst(s.st);
      end
      state_next = {st_next[1], st_next[0]};
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st_reg <= '{bank_idle, bank_idle};
         cnt_reg <= '{`SBBS_CNT_ZERO, `SBBS_CNT_ZERO};
         col_reg <= '{default: '0};
         rd_data_reg <= '0;
         rd_valid_reg <= 1'b0;
         illegal_reg <= 1'b0;
         busy_reg <= 1'b0;
         state_reg <= '0;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         col_reg <= col_next;
         rd_data_reg <= rd_data_next;
         rd_valid_reg <= rd_valid_next;
         illegal_reg <= illegal_next;
         busy_reg <= busy_next;
         state_reg <= state_next;
      end
   end

   // Storage is left unreset; only control state needs a defined value
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         store[wr_bank][wr_col] <= wr_word;
      end
   end

   assign lnk.rd_data = rd_data_reg;
   assign lnk.rd_valid = rd_valid_reg;
   assign illegal_cmd = illegal_reg;
   assign burst_active = busy_reg;
   assign bank_state = state_reg;
endmodule

/* File: bench/sbbs_chk.sv */
`timescale 1ns/100ps
`include "sbbs_map.svh"
module sbbs_chk (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic chip_select_n,
   input wire logic row_strobe_n,
   input wire logic column_strobe_n,
   input wire logic write_enable_n,
   input wire logic bank_select_bit,
   input wire logic autoclose_addr_bit,
   input wire logic rd_valid,
   input wire logic illegal_cmd,
   input wire logic [7:0] bank_state
);
   logic [3:0] pins;
   logic [3:0] st0;
   logic quiet;
   assign pins = {chip_select_n, row_strobe_n, column_strobe_n,
      write_enable_n};
   assign st0 = bank_state[3:0];
   assign quiet = chip_select_n || (pins == `SBBS_PINS_NOP);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence s_read0;
      pins == `SBBS_PINS_READ && !bank_select_bit;
   endsequence
   sequence s_write0;
      pins == `SBBS_PINS_WRITE && !bank_select_bit;
   endsequence
   sequence s_close0;
      pins == `SBBS_PINS_CLOSE && !bank_select_bit && st0 == 4'h1;
   endsequence
   rd_start_a: assert property (s_read0 |=> rd_valid &&
      st0 == ($past(autoclose_addr_bit) ? 4'h4 : 4'h2))
      else $error("read burst did not start");
   rd_end_a: assert property (s_read0 ##1 quiet |=>
      st0 == ($past(autoclose_addr_bit, 2) ? 4'h8 : 4'h1))
      else $error("read burst end state wrong");
   wr_start_a: assert property (s_write0 |=> !rd_valid &&
      st0 == ($past(autoclose_addr_bit) ? 4'h5 : 4'h3))
      else $error("write burst did not start");
   wr_recover_a: assert property (s_write0 ##0 !autoclose_addr_bit
      ##1 quiet |=> (st0 == 4'h6)[*2] ##1 st0 == 4'h1)
      else $error("write recovery wrong");
   wr_halt_a: assert property (st0 == 4'h3 &&
      pins == `SBBS_PINS_HALT |=> st0 == 4'h1)
      else $error("halt did not end write");
   pre_len_a: assert property (s_close0 |=>
      (st0 == 4'h8)[*3] ##1 st0 == 4'h0)
      else $error("precharge length wrong");
   rd_src_a: assert property ($rose(rd_valid) |->
      $past(pins) == `SBBS_PINS_READ)
      else $error("read word without read");
   ctl_legal_a: assert property (!illegal_cmd)
      else $error("forbidden command seen");
   desel_hold_a: assert property (chip_select_n && st0 == 4'h1
      |=> st0 == 4'h1)
      else $error("deselect changed state");
endmodule

/* File: bench/tb_sbbs.sv */
`timescale 1ns/100ps
`include "sbbs_map.svh"
module tb_sbbs;
   import sbbs_pkg::*;
   localparam logic [3:0] NP = `SBBS_PINS_NOP;
   localparam logic [3:0] HT = `SBBS_PINS_HALT;
   localparam logic [3:0] RD = `SBBS_PINS_READ;
   localparam logic [3:0] WR = `SBBS_PINS_WRITE;
   localparam logic [3:0] OP = `SBBS_PINS_OPEN;
   localparam logic [3:0] CL = `SBBS_PINS_CLOSE;
   localparam logic [3:0] RF = `SBBS_PINS_REFRESH;
   localparam logic [3:0] DS = `SBBS_PINS_DESEL;
   logic clk_sys;
   logic rstn;
   int bad_count = 0;
   int checks = 0;
   logic req_valid, req_ready, req_refused, req_bank;
   logic rd_word_valid, rd_word_ready, illegal_a, illegal_b, busy_b;
   sbbs_op_t req_op;
   logic [3:0] req_col, pins_a;
   logic [15:0] req_wdata, rd_word;
   logic [7:0] bank_state_a, bank_state_b;
   sbbs_if lnk_a();
   sbbs_if lnk_b();
   assign pins_a = {lnk_a.chip_select_n, lnk_a.row_strobe_n,
      lnk_a.column_strobe_n, lnk_a.write_enable_n};
   sbbs_ctl i_sbbs_ctl (
      .clk_sys(clk_sys), .rstn(rstn), .lnk(lnk_a),
      .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
      .req_bank(req_bank), .req_col(req_col), .req_wdata(req_wdata),
      .req_refused(req_refused), .rd_word_valid(rd_word_valid),
      .rd_word_ready(rd_word_ready), .rd_word(rd_word));
   sbbs_mem i_sbbs_mem (
      .clk_sys(clk_sys), .rstn(rstn), .lnk(lnk_a),
      .illegal_cmd(illegal_a), .burst_active(), .bank_state(bank_state_a));
   // Second device, driven straight by the bench to reach forbidden cases
   sbbs_mem i_sbbs_mem_2 (
      .clk_sys(clk_sys), .rstn(rstn), .lnk(lnk_b),
      .illegal_cmd(illegal_b), .burst_active(busy_b),
      .bank_state(bank_state_b));
   sbbs_chk i_sbbs_chk (.clk_sys(clk_sys), .rstn(rstn),
      .chip_select_n(lnk_a.chip_select_n), .row_strobe_n(lnk_a.row_strobe_n),
      .column_strobe_n(lnk_a.column_strobe_n),
      .write_enable_n(lnk_a.write_enable_n),
      .bank_select_bit(lnk_a.bank_select_bit),
      .autoclose_addr_bit(lnk_a.autoclose_addr_bit),
      .rd_valid(lnk_a.rd_valid), .illegal_cmd(illegal_a),
      .bank_state(bank_state_a));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task finish_test;
      $display("bad_count=%0d checks=%0d", bad_count, checks);
      if (bad_count == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task drive(input logic [3:0] p, input logic [1:0] ba);
      {lnk_b.chip_select_n, lnk_b.row_strobe_n, lnk_b.column_strobe_n,
         lnk_b.write_enable_n} = p;
      {lnk_b.bank_select_bit, lnk_b.autoclose_addr_bit} = ba;
      // Column and data keep moving so stale values never look valid
      lnk_b.col_addr = lnk_b.col_addr + 4'h3;
      lnk_b.wr_data = ~lnk_b.wr_data;
   endtask

   task step(input logic [3:0] p, input logic [1:0] ba,
      input logic [7:0] st, input logic [1:0] ir);
      logic busy;
      // Burst states are read, write and their autoclose forms
      busy = (st[3:0] >= 4'h2 && st[3:0] <= 4'h5) ||
         (st[7:4] >= 4'h2 && st[7:4] <= 4'h5);
      drive(p, ba);
      @(negedge clk_sys);
      chk({bank_state_b, illegal_b, lnk_b.rd_valid}, {st, ir});
      chk(busy_b, busy);
   endtask

   task settle;
      int n;
      n = 0;
      drive(DS, 2'h0);
      while (bank_state_b !== 8'h00 && n < 8) begin
         @(negedge clk_sys);
         n++;
      end
      chk(bank_state_b, 8'h00);
   endtask

   task req(input sbbs_op_t op, input logic bk, input logic [3:0] col,
      input logic [15:0] d);
      int n;
      n = 0;
      req_valid = 1'b1;
      req_op = op;
      req_bank = bk;
      req_col = col;
      req_wdata = d;
      while (req_ready !== 1'b1 && n < 40) begin
         @(negedge clk_sys);
         n++;
      end
      // A request that is never taken counts against the run
      chk(req_ready, 1'b1);
      @(negedge clk_sys);
   endtask

   task get_word(input logic [15:0] exp);
      int n;
      n = 0;
      while (rd_word_valid !== 1'b1 && n < 20) begin
         @(negedge clk_sys);
         n++;
      end
      chk(rd_word_valid, 1'b1);
      chk(rd_word, exp);
      rd_word_ready = 1'b1;
      @(negedge clk_sys);
      rd_word_ready = 1'b0;
      // One idle edge keeps the ready low between back-to-back takes
      @(negedge clk_sys);
   endtask

   task t_pair;
      req(op_open, 1'b0, 4'h0, 16'h0000);
      chk(pins_a, OP);
      req(op_write, 1'b0, 4'h2, 16'h1234);
      req(op_nop, 1'b0, 4'h0, 16'h5678);
      req_valid = 1'b0;
      repeat (4) @(negedge clk_sys);
      req(op_write, 1'b0, 4'h5, 16'h0bad);
      req(op_halt, 1'b0, 4'h0, 16'h0000);
      req(op_read, 1'b0, 4'h2, 16'h0000);
      req_valid = 1'b0;
      // Reader stalls: both words must wait in the buffer
      repeat (6) @(negedge clk_sys);
      chk(req_ready, 1'b0);
      get_word(16'h1234);
      get_word(16'h5678);
      req(op_read_ac, 1'b0, 4'h2, 16'h0000);
      req_valid = 1'b0;
      get_word(16'h1234);
      get_word(16'h5678);
      repeat (6) @(negedge clk_sys);
      req(op_open, 1'b0, 4'h0, 16'h0000);
      req(op_close, 1'b0, 4'h0, 16'h0000);
      req(op_read, 1'b1, 4'h0, 16'h0000);
      req_valid = 1'b0;
      chk({req_refused, pins_a}, {1'b1, DS});
   endtask

   task t_rd_run;
      step(OP, 2'h0, 8'h01, 2'h0);
      step(RD, 2'h0, 8'h02, 2'h1);
      step(DS, 2'h0, 8'h01, 2'h1);
      step(RD, 2'h0, 8'h02, 2'h1);
      step(HT, 2'h0, 8'h01, 2'h0);
      step(RD, 2'h0, 8'h02, 2'h1);
      step(RD, 2'h0, 8'h02, 2'h1);
      step(NP, 2'h0, 8'h01, 2'h1);
   endtask

   task t_rd_wr;
      step(RD, 2'h0, 8'h02, 2'h1);
      step(WR, 2'h0, 8'h03, 2'h0);
      step(4'h8, 2'h0, 8'h06, 2'h0);
      step(NP, 2'h0, 8'h06, 2'h0);
      step(NP, 2'h0, 8'h01, 2'h0);
   endtask

   task t_wr_irq;
      step(WR, 2'h0, 8'h03, 2'h0);
      step(HT, 2'h0, 8'h01, 2'h0);
      step(WR, 2'h0, 8'h03, 2'h0);
      step(RD, 2'h0, 8'h02, 2'h1);
      step(NP, 2'h0, 8'h01, 2'h1);
      step(WR, 2'h0, 8'h03, 2'h0);
      step(WR, 2'h0, 8'h03, 2'h0);
      step(DS, 2'h0, 8'h06, 2'h0);
      step(DS, 2'h0, 8'h06, 2'h0);
      step(DS, 2'h0, 8'h01, 2'h0);
   endtask

   task t_pre;
      step(RD, 2'h0, 8'h02, 2'h1);
      step(OP, 2'h0, 8'h02, 2'h2);
      step(CL, 2'h0, 8'h08, 2'h0);
      step(CL, 2'h0, 8'h08, 2'h0);
      step(HT, 2'h0, 8'h08, 2'h0);
      step(NP, 2'h0, 8'h00, 2'h0);
      step(OP, 2'h0, 8'h01, 2'h0);
      step(WR, 2'h0, 8'h03, 2'h0);
      step(RF, 2'h0, 8'h03, 2'h2);
      step(CL, 2'h0, 8'h08, 2'h0);
      step(RD, 2'h0, 8'h08, 2'h2);
      settle();
   endtask

   task t_auto;
      step(OP, 2'h0, 8'h01, 2'h0);
      step(RD, 2'h1, 8'h04, 2'h1);
      step(HT, 2'h0, 8'h04, 2'h2);
      step(NP, 2'h0, 8'h08, 2'h1);
      step(NP, 2'h0, 8'h08, 2'h0);
      step(NP, 2'h0, 8'h08, 2'h0);
      step(NP, 2'h0, 8'h00, 2'h0);
      step(OP, 2'h0, 8'h01, 2'h0);
      step(WR, 2'h1, 8'h05, 2'h0);
      step(RD, 2'h0, 8'h05, 2'h2);
      step(NP, 2'h0, 8'h07, 2'h0);
      step(NP, 2'h0, 8'h07, 2'h0);
      step(NP, 2'h0, 8'h08, 2'h0);
      settle();
   endtask

   task t_banks;
      step(OP, 2'h0, 8'h01, 2'h0);
      step(RD, 2'h0, 8'h02, 2'h1);
      step(OP, 2'h2, 8'h11, 2'h1);
      step(CL, 2'h1, 8'h88, 2'h0);
      settle();
   endtask

   initial begin
      repeat (3000) @(posedge clk_sys);
      bad_count++;
      finish_test();
   end

   initial begin
      rstn = 1'b0;
      req_valid = 1'b0;
      req_op = op_nop;
      req_bank = 1'b0;
      req_col = 4'h0;
      req_wdata = 16'h0000;
      rd_word_ready = 1'b0;
      lnk_b.col_addr = 4'h0;
      lnk_b.wr_data = 16'h0000;
      drive(DS, 2'h0);
      repeat (20) @(negedge clk_sys);
      rstn = 1'b1;
      @(negedge clk_sys);
      t_pair();
      t_rd_run();
      t_rd_wr();
      t_wr_irq();
      t_pre();
      t_auto();
      t_banks();
      finish_test();
   end
endmodule
